/* File: bench/scc_link_asserts.sv */
// link-level checks on the serial link joining host and device
`timescale 1ns/1ps
module scc_link_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic select_low,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sck_idle_low_a: assert property (select_low |-> !sck)
    else $error("sck moved outside a frame");
  frame_lead_a: assert property ($fell(select_low) |-> !sck[*8])
    else $error("sck rose too soon after select");
  first_rise_a: assert property ($fell(select_low) |-> ##[8:12] $rose(sck))
    else $error("first sck rise out of place");
  high_phase_a: assert property ($rose(sck) |-> sck[*8])
    else $error("sck high phase too short");
  low_phase_a: assert property ($fell(sck) && !select_low |-> !sck[*8])
    else $error("sck low phase too short");
  sdi_setup_a: assert property ($rose(sck) |-> $stable(sdi))
    else $error("sdi moved at sck rise");
  sdo_after_fall_a: assert property (
    (!select_low && !$past(select_low) && $changed(sdo)) |-> !sck)
    else $error("sdo moved while sck high");
  frame_gap_a: assert property ($rose(select_low) |-> select_low[*3])
    else $error("select gap too short");
  frame_tail_a: assert property ($rose(select_low) |-> !$past(sck, 8))
    else $error("select rose too close to sck");
endmodule : scc_link_asserts

/* File: bench/tb_top.sv */
// bench: host faces device; a second device takes hand-made faulty frames
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [11:0] addr = 12'h000;
  logic [7:0] cnt = 8'h00;
  logic [7:0] wr_byte;
  logic [7:0] wbuf [0:3];
  logic clr_m = 1'b0;
  logic clr_f = 1'b0;
  logic byte_req, rd_valid, crc_ok, done, rwe1, rwe2, mwe1, mwe2, mrd1, fm1, ff1, fm2, ff2;
  logic crc_bad, busy;
  logic [7:0] rd_data, rwd1;
  logic [11:0] aa1, ma;
  logic [31:0] mwd1, mw;
  logic [15:0] cst2, c;
  logic [95:0] bv;
  logic [31:0] sh = 32'h0;
  logic [31:0] so = 32'h0;
  logic sp = 1'b0;
  logic [7:0] rq [0:7];
  logic [11:0] wa [0:7];
  logic [7:0] wd [0:7];
  int widx, nw1, nm1, nr1, nrd, nok, nbad, nw2, nm2, cycles;
  int mismatches = 0;
  int cmp_count = 0;
  scc_link lk ();
  scc_link l2 ();
  assign wr_byte = wbuf[widx % 4];
  scc_host u_scc_host (.mclk(mclk), .rst(rst), .link(lk), .go(go), .cmd(cmd), .addr(addr),
    .cnt(cnt), .wr_byte(wr_byte), .byte_req(byte_req), .rd_valid(rd_valid),
    .rd_data(rd_data), .crc_ok(crc_ok), .crc_bad(crc_bad), .done(done), .busy(busy));
  scc_dev u_scc_dev (.mclk(mclk), .rst(rst), .link(lk), .acc_addr(aa1), .reg_we(rwe1),
    .reg_wdata(rwd1), .reg_rdata(aa1[7:0] ^ 8'h5a), .ram_we(mwe1), .ram_rd(mrd1),
    .ram_wdata(mwd1), .ram_rdata(32'hd4c3b2a1), .crc_mismatch_flag(fm1),
    .crc_frame_error_flag(ff1), .crc_status(), .clr_mismatch(clr_m), .clr_frame(clr_f));
  scc_dev u_scc_dev2 (.mclk(mclk), .rst(rst), .link(l2), .acc_addr(), .reg_we(rwe2),
    .reg_wdata(), .reg_rdata(8'h00), .ram_we(mwe2), .ram_rd(), .ram_wdata(),
    .ram_rdata(32'h00000000), .crc_mismatch_flag(fm2), .crc_frame_error_flag(ff2),
    .crc_status(cst2), .clr_mismatch(clr_m), .clr_frame(clr_f));
  scc_link_asserts u_scc_link_asserts (.mclk(mclk), .rst(rst), .select_low(lk.select_low),
    .sck(lk.sck), .sdi(lk.sdi), .sdo(lk.sdo));
  initial begin
    forever #4 mclk = ~mclk;
  end
  // sniff the wire at each sck rise, and count the strobes of both devices
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    sp <= lk.sck;
    if (lk.sck && !sp) begin
      sh <= {sh[30:0], lk.sdi};
      so <= {so[30:0], lk.sdo};
    end
    if (byte_req) widx <= widx + 1;
    if (rd_valid) begin
      rq[nrd % 8] <= rd_data;
      nrd <= nrd + 1;
    end
    if (rwe1) begin
      wa[nw1 % 8] <= aa1;
      wd[nw1 % 8] <= rwd1;
      nw1 <= nw1 + 1;
    end
    if (mwe1) begin
      ma <= aa1;
      mw <= mwd1;
      nm1 <= nm1 + 1;
    end
    if (mrd1) nr1 <= nr1 + 1;
    if (crc_ok) nok <= nok + 1;
    if (crc_bad) nbad <= nbad + 1;
    if (rwe2) nw2 <= nw2 + 1;
    if (mwe2) nm2 <= nm2 + 1;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end
  function automatic logic [15:0] crc_of(input logic [95:0] v, input int nb);
    logic [15:0] r;
    int k;
    r = 16'hffff;
    for (k = 0; k < nb * 8; k++) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ v[95 - k]) ? 16'h8005 : 16'h0000);
    end
    return r;
  endfunction : crc_of
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // counters are only touched between frames, when no strobe can land
  task automatic zc;
    widx = 0;
    nw1 = 0;
    nm1 = 0;
    nr1 = 0;
    nrd = 0;
    nok = 0;
    nbad = 0;
    nw2 = 0;
    nm2 = 0;
  endtask : zc
  task automatic host_op(input logic [3:0] c_i, input logic [11:0] a_i, input logic [7:0] n_i);
    zc();
    @(posedge mclk);
    cmd <= c_i;
    addr <= a_i;
    cnt <= n_i;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    chk(busy, 1);
    // a hung frame is caught by the global cycle ceiling
    while (done !== 1'b1) @(posedge mclk);
    repeat (8) @(posedge mclk);
  endtask : host_op
  // bit-banged master on the second link, sends nb bytes of bv msb first
  task automatic bb(input int nb);
    int k;
    zc();
    @(posedge mclk);
    l2.select_low <= 1'b0;
    for (k = 0; k < nb * 8; k++) begin
      l2.sdi <= bv[95 - k];
      repeat (10) @(posedge mclk);
      l2.sck <= 1'b1;
      repeat (10) @(posedge mclk);
      l2.sck <= 1'b0;
    end
    repeat (10) @(posedge mclk);
    l2.select_low <= 1'b1;
    l2.sdi <= ~l2.sdi;
    repeat (20) @(posedge mclk);
  endtask : bb
  task automatic clr;
    clr_m <= 1'b1;
    clr_f <= 1'b1;
    @(posedge mclk);
    clr_m <= 1'b0;
    clr_f <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : clr
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  initial begin
    l2.select_low = 1'b1;
    l2.sck = 1'b0;
    l2.sdi = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    wbuf = '{8'ha5, 8'h3c, 8'h00, 8'h00};
    host_op(4'ha, 12'h3ff, 8'h02);
    bv = {40'ha3ff02a53c, 56'h0};
    chk(nw1, 2);
    chk({wa[0], wd[0], wa[1], wd[1]}, {12'h3ff, 8'ha5, 12'h000, 8'h3c});
    chk(sh, {16'ha53c, crc_of(bv, 5)});
    chk({fm1, ff1}, 0);
    host_op(4'hb, 12'h010, 8'h02);
    bv = {40'hb010024a4b, 56'h0};
    chk({rq[0], rq[1], nok}, {8'h4a, 8'h4b, 32'd1});
    chk(so[15:0], crc_of(bv, 5));
    chk(fm1, 0);
    chk(nbad, 0);
    wbuf = '{8'h77, 8'h00, 8'h00, 8'h00};
    host_op(4'hc, 12'h020, 8'h00);
    bv = {24'hc02077, 72'h0};
    chk({nw1, wa[0], wd[0]}, {32'd1, 12'h020, 8'h77});
    chk(sh[15:0], crc_of(bv, 3));
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
    host_op(4'ha, 12'h400, 8'h01);
    chk({nm1, ma[11:2], mw}, {32'd1, 10'h100, 32'h44332211});
    host_op(4'hb, 12'h400, 8'h01);
    bv = {56'hb40001a1b2c3d4, 40'h0};
    chk({rq[0], rq[1], rq[2], rq[3], nok}, {32'ha1b2c3d4, 32'd1});
    chk(so[15:0], crc_of(bv, 7));
    chk(nr1 != 0, 1);
    chk(nbad, 0);
    wbuf = '{8'h55, 8'h66, 8'h77, 8'h88};
    host_op(4'hc, 12'h404, 8'h00);
    chk({nm1, mw}, {32'd1, 32'h88776655});
    // faulty frames: corrupted crc, early deselect, partial ram word
    bv = {24'hc03099, 72'h0};
    c = crc_of(bv, 3);
    bv[71:56] = c ^ 16'h0001;
    bb(5);
    chk({nw2, fm2, ff2}, {32'd0, 2'b10});
    chk(cst2, c);
    clr();
    bv = {32'ha040015e, 64'h0};
    c = crc_of(bv, 4);
    bv[63:48] = c ^ 16'h0001;
    bb(6);
    chk(nw2, 1);
    chk({fm2, ff2}, 2'b10);
    clr();
    bv[63:48] = c;
    bb(5);
    chk({fm2, ff2}, 2'b01);
    clr();
    bv = {24'hb01002, 72'h0};
    bb(4);
    chk({fm2, ff2}, 2'b01);
    clr();
    bv = {64'ha400021122334455, 32'h0};
    bb(8);
    chk({nm2, ff2}, {32'd1, 1'b1});
    clr();
    bv = {48'hc40801020304, 48'h0};
    c = crc_of(bv, 6);
    bv[47:32] = c ^ 16'h0001;
    bb(8);
    chk({nm2, fm2}, {32'd0, 1'b1});
    summarize();
  end
endmodule : tb_top

/* File: include/scc_defs.svh */
// constants for the crc-protected serial command engine
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_CMD_WR_CHECKED 4'ha
`define SCC_CMD_RD_CHECKED 4'hb
`define SCC_CMD_WR_GUARDED 4'hc
`define SCC_CRC_INIT 16'hffff
`define SCC_CRC_POLY 16'h8005
`define SCC_RAM_LO 12'h400
`define SCC_RAM_HI 12'hbff
`define SCC_SFR_TOP 12'h3ff
`define SCC_SFR_BASE 12'h000
`define SCC_HI_TOP 12'hfff
`define SCC_HI_BASE 12'he00
`define SCC_WORD_LAST 2'h3
`define SCC_MCLK_NS 8
`define SCC_SCK_NS 160
`define SCC_HALF_CYC ((`SCC_SCK_NS / `SCC_MCLK_NS) / 2)
`define SCC_DIV_W 5
`endif

/* File: include/scc_link.sv */
// serial link between host master and device
`timescale 1ns/1ps
interface scc_link;
  logic select_low;
  logic sck;
  logic sdi;
  logic sdo;
  modport dev (input select_low, input sck, input sdi, output sdo);
  modport host (output select_low, output sck, output sdi, input sdo);
endinterface : scc_link

/* File: include/scc_pkg.sv */
// types shared by both ends of the serial command link
package scc_pkg;
  typedef enum logic [2:0] {
    st_hdr = 3'h0,
    st_cnt = 3'h1,
    st_data = 3'h3,
    st_crc = 3'h2,
    st_done = 3'h6,
    st_ign = 3'h7
  } scc_dev_st_t;
  typedef enum logic [1:0] {
    hs_idle = 2'h0,
    hs_shift = 2'h1,
    hs_end = 2'h3
  } scc_host_st_t;
endpackage : scc_pkg

/* File: verilog/scc_dev.sv */
// device end: crc-checked serial command engine
`timescale 1ns/1ps
`include "scc_defs.svh"
module scc_dev (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  scc_link.dev link,
  // register and ram access
  output logic [11:0] acc_addr,
  output logic reg_we,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic ram_we,
  output logic ram_rd,
  output logic [31:0] ram_wdata,
  input wire logic [31:0] ram_rdata,
  // status
  output logic crc_mismatch_flag,
  output logic crc_frame_error_flag,
  output logic [15:0] crc_status,
  input wire logic clr_mismatch,
  input wire logic clr_frame
);
  scc_pkg::scc_dev_st_t st;
  logic [2:0] sck_s, cs_s;
  logic [1:0] sdi_s;
  logic [15:0] sh, crc, crc_tx;
  logic [2:0] bitn;
  logic full, first, crc_b, crc_cmd, ram_sel, ld_sfr, ld_ram, mm_ev, fe_ev;
  logic [3:0] cmd;
  logic [11:0] cur;
  logic [9:0] rem;
  logic [1:0] wbi;
  logic [31:0] word, rd_word;
  logic [7:0] out_sh, crc_hi;

  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire sel = ~cs_s[1];
  wire cs_fall = ~cs_s[1] & cs_s[2];
  wire cs_rise = cs_s[1] & ~cs_s[2];
  wire is_rd = cmd == `SCC_CMD_RD_CHECKED;
  wire is_safe = cmd == `SCC_CMD_WR_GUARDED;
  wire last = rem == 10'h001;
  wire [3:0] hcmd = sh[15:12];
  wire hdr_ram = sh[11:0] >= `SCC_RAM_LO && sh[11:0] <= `SCC_RAM_HI;
  wire hdr_crc = hcmd == `SCC_CMD_WR_CHECKED || hcmd == `SCC_CMD_RD_CHECKED ||
    hcmd == `SCC_CMD_WR_GUARDED;
  wire [9:0] cnt_bytes = ram_sel ? {sh[7:0], 2'b00} : {2'b00, sh[7:0]};
  wire [1:0] wbi_n = wbi + 2'h1;
  wire [7:0] rd_next = rd_word[{wbi_n, 3'b000} +: 8];
  wire crc_mis = {crc_hi, sh[7:0]} != crc_tx;
  // read data feeds the crc from what goes out, all else from what comes in
  wire crc_bit = (is_rd && st == scc_pkg::st_data) ? out_sh[7] : sdi_s[1];
  wire [15:0] crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ crc_bit) ? `SCC_CRC_POLY : 16'h0000);
  wire crc_run = st == scc_pkg::st_hdr || st == scc_pkg::st_cnt || st == scc_pkg::st_data;
  // address advance wraps inside each region
  wire [11:0] nxt = (cur == `SCC_SFR_TOP) ? `SCC_SFR_BASE :
    (cur == `SCC_HI_TOP) ? `SCC_HI_BASE :
    (cur == `SCC_RAM_HI) ? `SCC_RAM_LO : cur + 12'h001;

  assign link.sdo = out_sh[7];

  // pins come from the host's domain: two flops before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_s <= 3'h0;
      cs_s <= 3'h7;
      sdi_s <= 2'h0;
    end else begin
      sck_s <= {sck_s[1:0], link.sck};
      cs_s <= {cs_s[1:0], link.select_low};
      sdi_s <= {sdi_s[0], link.sdi};
    end
  end

  // set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_mismatch_flag <= 1'b0;
      crc_frame_error_flag <= 1'b0;
    end else begin
      crc_mismatch_flag <= (crc_mismatch_flag & ~clr_mismatch) | mm_ev;
      crc_frame_error_flag <= (crc_frame_error_flag & ~clr_frame) | fe_ev;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= scc_pkg::st_ign;
      sh <= 16'h0000;
      crc <= `SCC_CRC_INIT;
      crc_tx <= 16'h0000;
      crc_status <= 16'h0000;
      bitn <= 3'h0;
      {full, first, crc_b, crc_cmd, ram_sel, ld_sfr, ld_ram, mm_ev, fe_ev} <= 9'h000;
      cmd <= 4'h0;
      cur <= 12'h000;
      rem <= 10'h000;
      wbi <= 2'h0;
      word <= 32'h0000_0000;
      rd_word <= 32'h0000_0000;
      out_sh <= 8'h00;
      crc_hi <= 8'h00;
      acc_addr <= 12'h000;
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      ram_we <= 1'b0;
      ram_rd <= 1'b0;
      ram_wdata <= 32'h0000_0000;
    end else begin
      reg_we <= 1'b0;
      ram_we <= 1'b0;
      ram_rd <= 1'b0;
      ld_sfr <= 1'b0;
      mm_ev <= 1'b0;
      fe_ev <= 1'b0;
      ld_ram <= ram_rd;
      if (ld_sfr) out_sh <= reg_rdata;
      if (ld_ram) begin
        rd_word <= ram_rdata;
        out_sh <= ram_rdata[7:0];
      end
      if (cs_fall) begin
        st <= scc_pkg::st_hdr;
        crc <= `SCC_CRC_INIT;
        bitn <= 3'h0;
        full <= 1'b0;
        first <= 1'b1;
        crc_cmd <= 1'b0;
        wbi <= 2'h0;
        out_sh <= 8'h00;
      end else if (cs_rise) begin
        fe_ev <= crc_cmd && st != scc_pkg::st_done;
        st <= scc_pkg::st_ign;
      end else if (sel && sck_rise) begin
        sh <= {sh[14:0], sdi_s[1]};
        bitn <= bitn + 3'h1;
        full <= bitn == 3'h7;
        if (crc_run) crc <= crc_step;
      end else if (sel && sck_fall && !full) begin
        out_sh <= {out_sh[6:0], 1'b0};
      end else if (sel && sck_fall) begin
        full <= 1'b0;
        unique case (st)
          scc_pkg::st_hdr: begin
            first <= 1'b0;
            if (!first) begin
              cmd <= hcmd;
              cur <= sh[11:0];
              ram_sel <= hdr_ram;
              crc_cmd <= hdr_crc;
              if (hcmd == `SCC_CMD_WR_CHECKED || hcmd == `SCC_CMD_RD_CHECKED) begin
                st <= scc_pkg::st_cnt;
              end else if (hcmd == `SCC_CMD_WR_GUARDED) begin
                st <= scc_pkg::st_data;
                rem <= hdr_ram ? 10'h004 : 10'h001;
              end else begin
                st <= scc_pkg::st_ign;
              end
            end
          end
          scc_pkg::st_cnt: begin
            rem <= cnt_bytes;
            if (cnt_bytes == 10'h000) begin
              st <= scc_pkg::st_crc;
              crc_tx <= crc;
              crc_b <= 1'b0;
              if (is_rd) out_sh <= crc[15:8];
            end else begin
              st <= scc_pkg::st_data;
              if (is_rd) begin
                acc_addr <= cur;
                ram_rd <= ram_sel;
                ld_sfr <= !ram_sel;
              end
            end
          end
          scc_pkg::st_data: begin
            rem <= rem - 10'h001;
            wbi <= wbi_n;
            if (is_rd) begin
              cur <= nxt;
              if (!last && ram_sel && wbi == `SCC_WORD_LAST) begin
                acc_addr <= nxt;
                ram_rd <= 1'b1;
              end else if (!last && ram_sel) begin
                out_sh <= rd_next;
              end else if (!last) begin
                acc_addr <= nxt;
                ld_sfr <= 1'b1;
              end
            end else begin
              word[{wbi, 3'b000} +: 8] <= sh[7:0];
              if (!is_safe) begin
                cur <= nxt;
                acc_addr <= cur;
                reg_we <= !ram_sel;
                reg_wdata <= sh[7:0];
                ram_we <= ram_sel && wbi == `SCC_WORD_LAST;
                ram_wdata <= {sh[7:0], word[23:0]};
              end
            end
            if (last) begin
              st <= scc_pkg::st_crc;
              crc_tx <= crc;
              crc_b <= 1'b0;
              if (is_rd) out_sh <= crc[15:8];
            end
          end
          scc_pkg::st_crc: begin
            crc_b <= 1'b1;
            if (!crc_b) begin
              crc_hi <= sh[7:0];
              if (is_rd) out_sh <= crc_tx[7:0];
            end else begin
              st <= scc_pkg::st_done;
              // reads raise no mismatch; the host judges them
              if (!is_rd && crc_mis) begin
                mm_ev <= 1'b1;
                crc_status <= crc_tx;
              end else if (is_safe) begin
                acc_addr <= cur;
                reg_we <= !ram_sel;
                reg_wdata <= word[7:0];
                ram_we <= ram_sel;
                ram_wdata <= word;
              end
            end
          end
          scc_pkg::st_done, scc_pkg::st_ign: begin
          end
          default: st <= scc_pkg::st_ign;
        endcase
      end
    end
  end
endmodule : scc_dev

/* File: verilog/scc_host.sv */
// host end: serial master issuing crc-protected commands
`timescale 1ns/1ps
`include "scc_defs.svh"
module scc_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  scc_link.host link,
  // command request
  input wire logic go,
  input wire logic [3:0] cmd,
  input wire logic [11:0] addr,
  input wire logic [7:0] cnt,
  input wire logic [7:0] wr_byte,
  // answers
  output logic byte_req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic crc_ok,
  output logic crc_bad,
  output logic done,
  output logic busy
);
  scc_pkg::scc_host_st_t st;
  logic [`SCC_DIV_W-1:0] div;
  logic sck_r, sel_n;
  logic [7:0] tx, rx, rx_hi, cnt_r;
  logic [2:0] bitn;
  logic [9:0] bidx, nd;
  logic [1:0] hlen;
  logic [3:0] rcmd;
  logic [11:0] addr_r;
  logic [15:0] crc;
  logic [1:0] sdo_s;

  wire ram_in = addr >= `SCC_RAM_LO && addr <= `SCC_RAM_HI;
  wire [9:0] nd_in = (cmd == `SCC_CMD_WR_GUARDED) ? (ram_in ? 10'h004 : 10'h001) :
    (ram_in ? {cnt, 2'b00} : {2'b00, cnt});
  wire [1:0] hlen_in = (cmd == `SCC_CMD_WR_GUARDED) ? 2'h2 : 2'h3;
  wire tick = div == `SCC_DIV_W'(`SCC_HALF_CYC - 1);
  wire host_rd = rcmd == `SCC_CMD_RD_CHECKED;
  wire [9:0] dend = {8'h00, hlen} + nd;
  wire [9:0] nb = bidx + 10'h001;
  wire in_data = bidx >= {8'h00, hlen} && bidx < dend;
  wire nb_data = nb >= {8'h00, hlen} && nb < dend;
  wire crc_bit = (host_rd && in_data) ? sdo_s[1] : tx[7];
  wire [15:0] crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ crc_bit) ? `SCC_CRC_POLY : 16'h0000);
  // read frames send zeros once the header and count byte are out
  wire [7:0] next_tx = (nb == 10'h001) ? addr_r[7:0] :
    (nb == 10'h002 && hlen == 2'h3) ? cnt_r :
    nb_data ? (host_rd ? 8'h00 : wr_byte) :
    (nb == dend) ? (host_rd ? 8'h00 : crc[15:8]) :
    (host_rd ? 8'h00 : crc[7:0]);

  assign link.select_low = sel_n;
  assign link.sck = sck_r;
  assign link.sdi = tx[7];
  assign busy = st != scc_pkg::hs_idle;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdo_s <= 2'h0;
    end else begin
      sdo_s <= {sdo_s[0], link.sdo};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= scc_pkg::hs_idle;
      div <= '0;
      sck_r <= 1'b0;
      sel_n <= 1'b1;
      tx <= 8'h00;
      rx <= 8'h00;
      rx_hi <= 8'h00;
      cnt_r <= 8'h00;
      bitn <= 3'h0;
      bidx <= 10'h000;
      nd <= 10'h000;
      hlen <= 2'h2;
      rcmd <= 4'h0;
      addr_r <= 12'h000;
      crc <= `SCC_CRC_INIT;
      byte_req <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      crc_ok <= 1'b0;
      crc_bad <= 1'b0;
      done <= 1'b0;
    end else begin
      byte_req <= 1'b0;
      rd_valid <= 1'b0;
      crc_ok <= 1'b0;
      crc_bad <= 1'b0;
      done <= 1'b0;
      div <= (st == scc_pkg::hs_idle || tick) ? '0 : div + `SCC_DIV_W'(1);
      unique case (st)
        scc_pkg::hs_idle: begin
          if (go) begin
            st <= scc_pkg::hs_shift;
            sel_n <= 1'b0;
            crc <= `SCC_CRC_INIT;
            tx <= {cmd, addr[11:8]};
            rcmd <= cmd;
            addr_r <= addr;
            cnt_r <= cnt;
            nd <= nd_in;
            hlen <= hlen_in;
            bidx <= 10'h000;
            bitn <= 3'h0;
          end
        end
        scc_pkg::hs_shift: begin
          if (tick && !sck_r) begin
            sck_r <= 1'b1;
            rx <= {rx[6:0], sdo_s[1]};
            bitn <= bitn + 3'h1;
            if (bidx < dend) crc <= crc_step;
          end else if (tick) begin
            sck_r <= 1'b0;
            if (bitn != 3'h0) begin
              tx <= {tx[6:0], 1'b0};
            end else begin
              if (host_rd && in_data) begin
                rd_valid <= 1'b1;
                rd_data <= rx;
              end
              if (bidx == dend) rx_hi <= rx;
              if (bidx == dend + 10'h001) begin
                st <= scc_pkg::hs_end;
                crc_ok <= host_rd && {rx_hi, rx} == crc;
                crc_bad <= host_rd && {rx_hi, rx} != crc;
              end else begin
                bidx <= nb;
                tx <= next_tx;
                byte_req <= !host_rd && nb_data;
              end
            end
          end
        end
        scc_pkg::hs_end: begin
          if (tick && !sel_n) begin
            sel_n <= 1'b1;
          end else if (tick) begin
            st <= scc_pkg::hs_idle;
            done <= 1'b1;
          end
        end
        default: st <= scc_pkg::hs_idle;
      endcase
    end
  end
endmodule : scc_host
